// file: pkg/bridge_defs.svh
`ifndef BRIDGE_DEFS_SVH
`define BRIDGE_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define REG_PRIMARY_ADDR 8'h00
`define REG_GEN_CTRL     8'h02
`define REG_PAGE         8'h4c
`define REG_LOCK_STATUS  8'h4d
`define REG_BC_CFG       8'h58
`define REG_REMOTE_ADDR  8'h5d
`define REG_ALIAS0       8'hf8
`define REG_ALIAS1       8'hf9

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define GEN_CTRL_PROXY_BIT 5
`define PAGE_PORT_BIT      0
`define BC_CFG_RATE_BIT    0
`define BC_CFG_OVR_BIT     3
`define REG_RESET          8'h00
`define BC_CAPS_VALUE      8'h01
`define STRAP_ADDR_TABLE   {7'h3d, 7'h3c, 7'h3a, 7'h38, 7'h36, 7'h34, 7'h32, 7'h30}

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS   8
`define STRAP_WAIT_NS   1000000
`define STRAP_WAIT_CYC  ((`STRAP_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BC_FAST_GAP     9'd16
`define BC_SLOW_GAP     9'd320

`endif

// file: pkg/bridge_pkg.sv
package bridge_pkg;

	typedef enum logic [2:0] {
		BC_START = 3'b000,
		BC_WRITE = 3'b001,
		BC_READ  = 3'b010,
		BC_STOP  = 3'b011,
		BC_GPIO  = 3'b100,
		BC_CAPS  = 3'b101
	} bc_kind_t;

	typedef struct packed {
		bc_kind_t   kind;
		logic       port;
		logic [7:0] data;
	} bc_word_t;

	typedef struct packed {
		logic       remote;
		logic       port;
		logic       ack;
		logic [7:0] data;
	} bc_resp_t;

endpackage

// file: design/bc_link_end.sv
`timescale 1ns/100ps
`include "bridge_defs.svh"
module bc_link_end import bridge_pkg::*; (
	// Clock and reset
	input  wire logic       link_clk,
	input  wire logic       rstn,
	// Request and answer from the control domain
	input  wire logic       req_tgl,
	input  wire bc_word_t   req,
	output logic            ack_tgl,
	output bc_resp_t        resp,
	output logic            prx_tgl,
	output bc_resp_t        prx,
	// Levels from the control domain and pins
	input  wire logic [1:0] rate_fast,
	input  wire logic [3:0] gpio_pin,
	// Back channel words
	output logic            bc_tx_valid,
	output bc_word_t        bc_tx_word,
	input  wire logic       bc_tx_ready,
	input  wire logic       bc_rx_valid,
	input  wire bc_resp_t   bc_rx_resp
);

	typedef enum logic [1:0] {
		L_IDLE = 2'b00,
		L_SEND = 2'b01,
		L_WAIT = 2'b10
	} link_state_t;

	link_state_t state_q;
	logic        req_m_q, req_s_q, seen_q, wait_q;
	logic [1:0]  rate_m_q, rate_s_q, frame_q;
	logic [3:0]  gpio_m_q, gpio_s_q;
	logic [8:0]  gap_q, gap_lim;

	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			req_m_q  <= 1'b0;
			req_s_q  <= 1'b0;
			rate_m_q <= 2'b00;
			rate_s_q <= 2'b00;
			gpio_m_q <= 4'h0;
			gpio_s_q <= 4'h0;
		end else begin
			req_m_q  <= req_tgl;
			req_s_q  <= req_m_q;
			rate_m_q <= rate_fast;
			rate_s_q <= rate_m_q;
			gpio_m_q <= gpio_pin;
			gpio_s_q <= gpio_m_q;
		end
	end

	// Status frames are paced by the rate of the port they describe.
	assign gap_lim = rate_s_q[frame_q[1]] ? `BC_FAST_GAP : `BC_SLOW_GAP;

	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			state_q     <= L_IDLE;
			seen_q      <= 1'b0;
			wait_q      <= 1'b0;
			frame_q     <= 2'b00;
			gap_q       <= 9'd0;
			bc_tx_valid <= 1'b0;
			bc_tx_word  <= '0;
			ack_tgl     <= 1'b0;
			resp        <= '0;
			prx_tgl     <= 1'b0;
			prx         <= '0;
		end else begin
			if (gap_q != gap_lim) begin
				gap_q <= gap_q + 9'd1;
			end
			if (bc_rx_valid && bc_rx_resp.remote) begin
				prx     <= bc_rx_resp;
				prx_tgl <= ~prx_tgl;
			end
			unique case (state_q)
				L_IDLE: begin
					if (req_s_q != seen_q) begin
						seen_q      <= req_s_q;
						bc_tx_word  <= req;
						bc_tx_valid <= 1'b1;
						wait_q      <= 1'b1;
						state_q     <= L_SEND;
					end else if (gap_q == gap_lim) begin
						gap_q            <= 9'd0;
						frame_q          <= frame_q + 2'd1;
						bc_tx_word.port  <= frame_q[1];
						bc_tx_word.kind  <= frame_q[0] ? BC_CAPS : BC_GPIO;
						bc_tx_word.data  <= frame_q[0] ? `BC_CAPS_VALUE : {4'h0, gpio_s_q};
						bc_tx_valid      <= 1'b1;
						wait_q           <= 1'b0;
						state_q          <= L_SEND;
					end
				end
				L_SEND: begin
					if (bc_tx_ready) begin
						bc_tx_valid <= 1'b0;
						state_q     <= wait_q ? L_WAIT : L_IDLE;
					end
				end
				L_WAIT: begin
					if (bc_rx_valid && !bc_rx_resp.remote) begin
						resp    <= bc_rx_resp;
						ack_tgl <= ~ack_tgl;
						state_q <= L_IDLE;
					end
				end
				default: state_q <= L_IDLE;
			endcase
		end
	end

endmodule

// file: design/serial_control_target_bridge.sv
`timescale 1ns/100ps
`include "bridge_defs.svh"
module serial_control_target_bridge import bridge_pkg::*; #(
	parameter int unsigned STRAP_WAIT = `STRAP_WAIT_CYC
) (
	// Clocks and reset
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       link_clk,
	// Serial control bus pins
	input  wire logic       scl_i,
	output logic            scl_o,
	output logic            scl_oe,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe,
	// Straps, lock status and GPIO
	input  wire logic [2:0] address_strap_pin,
	input  wire logic       mode_strap_pin,
	input  wire logic [1:0] rx_port_lock,
	input  wire logic [3:0] gpio_pin,
	// Back channel link side
	output logic            bc_tx_valid,
	output bc_word_t        bc_tx_word,
	input  wire logic       bc_tx_ready,
	input  wire logic       bc_rx_valid,
	input  wire bc_resp_t   bc_rx_resp,
	// Proxy controller hand-off and rate
	output logic            proxy_valid,
	output bc_resp_t        proxy_word,
	output logic [1:0]      bc_rate_fast
);

	localparam int WW = $clog2(STRAP_WAIT + 1);

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_ADDR = 3'b001,
		S_ACK  = 3'b010,
		S_WR   = 3'b011,
		S_RD   = 3'b100,
		S_RACK = 3'b101,
		S_FWD  = 3'b110
	} fsm_state_t;

	function automatic logic addr_hit(input logic [6:0] a, input logic [7:0] r);
		addr_hit = (r[7:1] != 7'h00) && (a == r[7:1]);
	endfunction

	function automatic logic [6:0] strap_addr(input logic [2:0] idx);
		logic [55:0] tbl;
		tbl = `STRAP_ADDR_TABLE;
		strap_addr = tbl[idx*7 +: 7];
	endfunction

	// ------------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------------
	logic       scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
	logic [2:0] strap_m_q, strap_s_q;
	logic       mode_m_q, mode_s_q;
	logic [1:0] lock_m_q, lock_s_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			scl_m_q   <= 1'b1;
			scl_s_q   <= 1'b1;
			scl_p_q   <= 1'b1;
			sda_m_q   <= 1'b1;
			sda_s_q   <= 1'b1;
			sda_p_q   <= 1'b1;
			strap_m_q <= 3'h0;
			strap_s_q <= 3'h0;
			mode_m_q  <= 1'b0;
			mode_s_q  <= 1'b0;
			lock_m_q  <= 2'h0;
			lock_s_q  <= 2'h0;
		end else begin
			scl_m_q   <= scl_i;
			scl_s_q   <= scl_m_q;
			scl_p_q   <= scl_s_q;
			sda_m_q   <= sda_i;
			sda_s_q   <= sda_m_q;
			sda_p_q   <= sda_s_q;
			strap_m_q <= address_strap_pin;
			strap_s_q <= strap_m_q;
			mode_m_q  <= mode_strap_pin;
			mode_s_q  <= mode_m_q;
			lock_m_q  <= rx_port_lock;
			lock_s_q  <= lock_m_q;
		end
	end

	// A 1 MHz bus leaves at least 60 clocks per SCL phase for these edges.
	logic start_c, stop_c, rise_c, fall_c;
	assign start_c = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
	assign stop_c  = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;
	assign rise_c  = scl_s_q && !scl_p_q;
	assign fall_c  = !scl_s_q && scl_p_q;

	// ------------------------------------------------------------------------
	// Strap sampling
	// ------------------------------------------------------------------------
	logic [WW-1:0] wait_q;
	logic          strap_done_q, strap_take;

	assign strap_take = !strap_done_q && (wait_q == WW'(STRAP_WAIT));

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wait_q       <= '0;
			strap_done_q <= 1'b0;
		end else if (strap_take) begin
			strap_done_q <= 1'b1;
		end else if (!strap_done_q) begin
			wait_q <= wait_q + WW'(1);
		end
	end

	// ------------------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------------------
	fsm_state_t state_q;
	logic [7:0] primary_q, gen_ctrl_q, page_q, alias0_q, alias1_q;
	logic [7:0] bc_cfg_q [2];
	logic [7:0] remote_q [2];
	logic [7:0] sh_q, ptr_q, rd_c;
	logic [3:0] cnt_q;
	logic       mode_q, first_q, fwd_q, alias_hit_q, alias_port_q, port_c, wr_c;

	assign port_c = alias_hit_q ? alias_port_q : page_q[`PAGE_PORT_BIT];
	assign wr_c   = (state_q == S_WR) && fall_c && (cnt_q == 4'd8) && !fwd_q && !first_q
		&& !start_c && !stop_c;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			primary_q   <= `REG_RESET;
			gen_ctrl_q  <= `REG_RESET;
			page_q      <= `REG_RESET;
			alias0_q    <= `REG_RESET;
			alias1_q    <= `REG_RESET;
			bc_cfg_q[0] <= `REG_RESET;
			bc_cfg_q[1] <= `REG_RESET;
			remote_q[0] <= `REG_RESET;
			remote_q[1] <= `REG_RESET;
			mode_q      <= 1'b0;
		end else if (strap_take) begin
			primary_q <= {strap_addr(strap_s_q), 1'b0};
			mode_q    <= mode_s_q;
		end else if (wr_c) begin
			case (ptr_q)
				`REG_PRIMARY_ADDR: primary_q        <= sh_q;
				`REG_GEN_CTRL:     gen_ctrl_q       <= sh_q;
				`REG_PAGE:         page_q           <= sh_q;
				`REG_BC_CFG:       bc_cfg_q[port_c] <= sh_q;
				`REG_REMOTE_ADDR:  remote_q[port_c] <= sh_q;
				`REG_ALIAS0:       alias0_q         <= sh_q;
				`REG_ALIAS1:       alias1_q         <= sh_q;
				default: ;
			endcase
		end
	end

	always_comb begin
		case (ptr_q)
			`REG_PRIMARY_ADDR: rd_c = primary_q;
			`REG_GEN_CTRL:     rd_c = gen_ctrl_q;
			`REG_PAGE:         rd_c = page_q;
			`REG_LOCK_STATUS:  rd_c = {6'h00, lock_s_q};
			`REG_BC_CFG:       rd_c = bc_cfg_q[port_c];
			`REG_REMOTE_ADDR:  rd_c = remote_q[port_c];
			`REG_ALIAS0:       rd_c = alias0_q;
			`REG_ALIAS1:       rd_c = alias1_q;
			default:           rd_c = 8'h00;
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bc_rate_fast <= 2'b00;
		end else begin
			for (int p = 0; p < 2; p++) begin
				bc_rate_fast[p] <= bc_cfg_q[p][`BC_CFG_OVR_BIT] ?
					bc_cfg_q[p][`BC_CFG_RATE_BIT] : mode_q;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Link crossing
	// ------------------------------------------------------------------------
	bc_word_t req_q, pend_word_q;
	bc_resp_t resp_w, prx_w;
	logic     req_tgl_q, ack_tgl_w, prx_tgl_w;
	logic     ack_m_q, ack_s_q, ack_p_q, prx_m_q, prx_s_q, prx_p_q, resp_evt, prx_evt;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ack_m_q <= 1'b0;
			ack_s_q <= 1'b0;
			ack_p_q <= 1'b0;
			prx_m_q <= 1'b0;
			prx_s_q <= 1'b0;
			prx_p_q <= 1'b0;
		end else begin
			ack_m_q <= ack_tgl_w;
			ack_s_q <= ack_m_q;
			ack_p_q <= ack_s_q;
			prx_m_q <= prx_tgl_w;
			prx_s_q <= prx_m_q;
			prx_p_q <= prx_s_q;
		end
	end

	assign resp_evt = ack_s_q ^ ack_p_q;
	assign prx_evt  = prx_s_q ^ prx_p_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			proxy_valid <= 1'b0;
			proxy_word  <= '0;
		end else begin
			proxy_valid <= prx_evt && gen_ctrl_q[`GEN_CTRL_PROXY_BIT];
			if (prx_evt) begin
				proxy_word <= prx_w;
			end
		end
	end

	bc_link_end u_link (
		.link_clk    (link_clk),
		.rstn        (rstn),
		.req_tgl     (req_tgl_q),
		.req         (req_q),
		.ack_tgl     (ack_tgl_w),
		.resp        (resp_w),
		.prx_tgl     (prx_tgl_w),
		.prx         (prx_w),
		.rate_fast   (bc_rate_fast),
		.gpio_pin    (gpio_pin),
		.bc_tx_valid (bc_tx_valid),
		.bc_tx_word  (bc_tx_word),
		.bc_tx_ready (bc_tx_ready),
		.bc_rx_valid (bc_rx_valid),
		.bc_rx_resp  (bc_rx_resp)
	);

	// ------------------------------------------------------------------------
	// Target state machine
	// ------------------------------------------------------------------------
	logic hit_pri, hit_a0, hit_a1, hit_r0, hit_r1, rw_q, rport_q, ack_drv_q, nack_q;
	logic busy_q, pend_q, wait_fwd_q, stop_pend_q, scl_oe_q, sda_oe_q, rel_q;

	assign hit_pri = addr_hit(sh_q[7:1], primary_q);
	assign hit_a0  = addr_hit(sh_q[7:1], alias0_q);
	assign hit_a1  = addr_hit(sh_q[7:1], alias1_q);
	assign hit_r0  = addr_hit(sh_q[7:1], remote_q[0]);
	assign hit_r1  = addr_hit(sh_q[7:1], remote_q[1]);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q      <= S_IDLE;
			sh_q         <= 8'h00;
			cnt_q        <= 4'h0;
			ptr_q        <= 8'h00;
			rw_q         <= 1'b0;
			first_q      <= 1'b0;
			fwd_q        <= 1'b0;
			rport_q      <= 1'b0;
			alias_hit_q  <= 1'b0;
			alias_port_q <= 1'b0;
			ack_drv_q    <= 1'b0;
			nack_q       <= 1'b0;
			busy_q       <= 1'b0;
			pend_q       <= 1'b0;
			wait_fwd_q   <= 1'b0;
			stop_pend_q  <= 1'b0;
			pend_word_q  <= '0;
			req_q        <= '0;
			req_tgl_q    <= 1'b0;
			scl_oe_q     <= 1'b0;
			sda_oe_q     <= 1'b0;
			rel_q        <= 1'b0;
		end else begin
			// The held clock line is let go one clock after the data line has been set up.
			rel_q <= 1'b0;
			if (rel_q) begin
				scl_oe_q <= 1'b0;
			end
			if (resp_evt) begin
				busy_q <= 1'b0;
			end
			if (stop_pend_q && !busy_q) begin
				req_q       <= '{BC_STOP, rport_q, 8'h00};
				req_tgl_q   <= ~req_tgl_q;
				busy_q      <= 1'b1;
				stop_pend_q <= 1'b0;
			end else if (pend_q && !busy_q) begin
				req_q      <= pend_word_q;
				req_tgl_q  <= ~req_tgl_q;
				busy_q     <= 1'b1;
				pend_q     <= 1'b0;
				wait_fwd_q <= 1'b1;
			end
			if (stop_c) begin
				state_q     <= S_IDLE;
				sda_oe_q    <= 1'b0;
				scl_oe_q    <= 1'b0;
				stop_pend_q <= fwd_q;
				fwd_q       <= 1'b0;
			end else if (start_c) begin
				// A repeated start inside a forwarded transfer readdresses the far side.
				state_q  <= S_ADDR;
				cnt_q    <= 4'h0;
				sda_oe_q <= 1'b0;
			end else begin
				unique case (state_q)
					S_IDLE: ;
					S_ADDR, S_WR: begin
						if (rise_c) begin
							sh_q  <= {sh_q[6:0], sda_s_q};
							cnt_q <= cnt_q + 4'd1;
						end else if (fall_c && cnt_q == 4'd8) begin
							cnt_q <= 4'h0;
							if (state_q == S_ADDR) begin
								rw_q    <= sh_q[0];
								first_q <= 1'b1;
								if (!strap_done_q) begin
									state_q <= S_IDLE;
								end else if (hit_pri || hit_a0 || hit_a1) begin
									alias_hit_q  <= hit_a0 || hit_a1;
									alias_port_q <= !hit_a0 && hit_a1;
									fwd_q        <= 1'b0;
									ack_drv_q    <= 1'b1;
									sda_oe_q     <= 1'b1;
									state_q      <= S_ACK;
								end else if ((hit_r0 && lock_s_q[0]) ||
									(hit_r1 && !hit_r0 && lock_s_q[1])) begin
									fwd_q       <= 1'b1;
									rport_q     <= !hit_r0;
									pend_word_q <= '{BC_START, !hit_r0, sh_q};
									pend_q      <= 1'b1;
									scl_oe_q    <= 1'b1;
									state_q     <= S_FWD;
								end else begin
									state_q <= S_IDLE;
								end
							end else if (fwd_q) begin
								pend_word_q <= '{BC_WRITE, rport_q, sh_q};
								pend_q      <= 1'b1;
								scl_oe_q    <= 1'b1;
								state_q     <= S_FWD;
							end else begin
								if (first_q) begin
									ptr_q   <= sh_q;
									first_q <= 1'b0;
								end else begin
									ptr_q <= ptr_q + 8'd1;
								end
								ack_drv_q <= 1'b1;
								sda_oe_q  <= 1'b1;
								state_q   <= S_ACK;
							end
						end
					end
					S_ACK: begin
						if (fall_c) begin
							sda_oe_q <= 1'b0;
							if (!ack_drv_q) begin
								state_q <= S_IDLE;
							end else if (rw_q && fwd_q) begin
								pend_word_q <= '{BC_READ, rport_q, 8'h00};
								pend_q      <= 1'b1;
								scl_oe_q    <= 1'b1;
								state_q     <= S_FWD;
							end else if (rw_q) begin
								sh_q     <= rd_c;
								sda_oe_q <= !rd_c[7];
								ptr_q    <= ptr_q + 8'd1;
								cnt_q    <= 4'd1;
								state_q  <= S_RD;
							end else begin
								state_q <= S_WR;
							end
						end
					end
					S_RD: begin
						if (fall_c && cnt_q != 4'd8) begin
							sda_oe_q <= !sh_q[6];
							sh_q     <= {sh_q[6:0], 1'b0};
							cnt_q    <= cnt_q + 4'd1;
						end else if (fall_c) begin
							sda_oe_q <= 1'b0;
							cnt_q    <= 4'h0;
							state_q  <= S_RACK;
						end
					end
					S_RACK: begin
						if (rise_c) begin
							nack_q <= sda_s_q;
						end else if (fall_c && nack_q) begin
							state_q <= S_IDLE;
						end else if (fall_c && fwd_q) begin
							pend_word_q <= '{BC_READ, rport_q, 8'h00};
							pend_q      <= 1'b1;
							scl_oe_q    <= 1'b1;
							state_q     <= S_FWD;
						end else if (fall_c) begin
							sh_q     <= rd_c;
							sda_oe_q <= !rd_c[7];
							ptr_q    <= ptr_q + 8'd1;
							cnt_q    <= 4'd1;
							state_q  <= S_RD;
						end
					end
					S_FWD: begin
						if (wait_fwd_q && resp_evt) begin
							wait_fwd_q <= 1'b0;
							rel_q      <= 1'b1;
							if (pend_word_q.kind == BC_READ) begin
								sh_q     <= resp_w.data;
								sda_oe_q <= !resp_w.data[7];
								cnt_q    <= 4'd1;
								state_q  <= S_RD;
							end else begin
								ack_drv_q <= resp_w.ack;
								sda_oe_q  <= resp_w.ack;
								state_q   <= S_ACK;
							end
						end
					end
					default: state_q <= S_IDLE;
				endcase
			end
		end
	end

	logic drive_low_q;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			drive_low_q <= 1'b0;
		end else begin
			drive_low_q <= 1'b0;
		end
	end

	assign scl_o  = drive_low_q;
	assign sda_o  = drive_low_q;
	assign scl_oe = scl_oe_q;
	assign sda_oe = sda_oe_q;

endmodule

// file: testbench/bridge_monitor.sv
`timescale 1ns/100ps
module bridge_monitor import bridge_pkg::*; #(
	parameter int unsigned STRAP_WAIT = 20
) (
	// Clocks and reset
	input wire logic     clk,
	input wire logic     rstn,
	input wire logic     link_clk,
	// Serial bus pins
	input wire logic     scl_i,
	input wire logic     scl_oe,
	input wire logic     sda_oe,
	// Back channel and proxy hand-off
	input wire logic     bc_tx_valid,
	input wire bc_word_t bc_tx_word,
	input wire logic     bc_tx_ready,
	input wire logic     proxy_valid,
	input wire bc_resp_t proxy_word
);
	int unsigned cnt_q;

	// Counts control clocks since reset release, up to the strap sampling point.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= 0;
		end else if (cnt_q <= STRAP_WAIT) begin
			cnt_q <= cnt_q + 1;
		end
	end

	property p_strap;
		@(posedge clk) disable iff (!rstn) cnt_q <= STRAP_WAIT |-> !sda_oe && !scl_oe;
	endproperty
	a_strap: assert property (p_strap) else $error("bus driven before strap");
	property p_sda_hold;
		@(posedge clk) disable iff (!rstn) $changed(sda_oe) |-> !scl_i;
	endproperty
	a_sda_hold: assert property (p_sda_hold) else $error("data moved, clock high");
	property p_stretch;
		@(posedge clk) disable iff (!rstn) $rose(scl_oe) |-> !$past(scl_i);
	endproperty
	a_stretch: assert property (p_stretch) else $error("stretch at clock high");
	property p_word_hold;
		@(posedge link_clk) disable iff (!rstn)
		bc_tx_valid && !bc_tx_ready |=> bc_tx_valid && $stable(bc_tx_word);
	endproperty
	a_word_hold: assert property (p_word_hold) else $error("word dropped");
	property p_caps;
		@(posedge link_clk) disable iff (!rstn)
		bc_tx_valid && bc_tx_word.kind == BC_CAPS |-> bc_tx_word.data == 8'h01;
	endproperty
	a_caps: assert property (p_caps) else $error("bad capability word");
	property p_gpio;
		@(posedge link_clk) disable iff (!rstn)
		bc_tx_valid && bc_tx_word.kind == BC_GPIO |-> bc_tx_word.data[7:4] == 4'h0;
	endproperty
	a_gpio: assert property (p_gpio) else $error("bad gpio word");
	property p_pulse;
		@(posedge clk) disable iff (!rstn) proxy_valid |=> !proxy_valid;
	endproperty
	a_pulse: assert property (p_pulse) else $error("proxy pulse too long");
	property p_proxy;
		@(posedge clk) disable iff (!rstn) proxy_valid |-> proxy_word.remote;
	endproperty
	a_proxy: assert property (p_proxy) else $error("proxy word not remote");
	c_proxy: cover property (@(posedge clk) proxy_valid);
	c_stretch: cover property (@(posedge clk) $rose(scl_oe));
	c_caps: cover property (@(posedge link_clk) bc_tx_valid && bc_tx_word.kind == BC_CAPS);
endmodule

bind serial_control_target_bridge bridge_monitor #(.STRAP_WAIT(STRAP_WAIT)) u_mon (
	.clk, .rstn, .link_clk, .scl_i, .scl_oe, .sda_oe,
	.bc_tx_valid, .bc_tx_word, .bc_tx_ready, .proxy_valid, .proxy_word
);

// file: testbench/bc_partner.sv
`timescale 1ns/100ps
module bc_partner import bridge_pkg::*; (
	// Link clock, reset and bench controls
	input  wire logic     link_clk,
	input  wire logic     rstn,
	input  wire logic     slow,
	input  wire logic     px,
	// Back channel words
	input  wire logic     v,
	input  wire bc_word_t w,
	output logic          rdy,
	output logic          rv,
	output bc_resp_t      r
);
	logic [7:0] la, lw, caps, dl;
	logic       pp, px_q;

	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			{la, lw, caps, dl, pp, px_q} <= '0;
			rdy <= 1'b0;
			rv <= 1'b0;
			r <= '0;
		end else begin
			rv <= 1'b0;
			// Released answer data lines never keep showing the last value.
			r.data <= ~r.data;
			rdy <= slow ? ~rdy : 1'b1;
			px_q <= px;
			if (dl != 8'd0) dl <= dl - 8'd1;
			if (v && rdy) begin
				if (w.kind == BC_START) la <= w.data;
				if (w.kind == BC_WRITE) lw <= w.data;
				if (w.kind == BC_CAPS) caps <= w.data;
				if (w.kind <= BC_STOP) begin
					dl <= slow ? 8'd60 : 8'd3;
					pp <= w.port;
				end
			end
			if (dl == 8'd1) begin
				rv <= 1'b1;
				r <= '{1'b0, pp, 1'b1, 8'ha5};
			end else if (px && !px_q) begin
				rv <= 1'b1;
				r <= '{1'b1, 1'b0, 1'b1, 8'h5a};
			end
		end
	end
endmodule

// file: testbench/test_serial_control_target_bridge.sv
`timescale 1ns/100ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_errors++; \
	$display("BAD %0t got %h exp %h", $time, a, e); end end
module test_serial_control_target_bridge import bridge_pkg::*; ;
	localparam int Q = 32;
	localparam int STW = 20;
	logic        clk = 0, link_clk = 0, rstn = 0, ms = 1, md = 1, slow = 0, px = 0, ea = 1;
	logic [1:0]  lock = 2'h3;
	logic [2:0]  strap_v = 3'h3;
	logic        mode_v = 1'b1;
	logic [3:0]  gp = 4'h0;
	logic [7:0]  mdl [512];
	logic [7:0]  rb;
	logic [31:0] lf = 32'd80836;
	int          n_errors = 0, samples_checked = 0, st = 0, cyc = 0;
	wire         scl_oe, sda_oe, scl_o, sda_o, bv, br, rv, pv;
	wire [1:0]   rf;
	wire bc_word_t bw;
	wire bc_resp_t rr, pw;
	wire         scl = ms & (~scl_oe | scl_o);
	wire         sda = md & (~sda_oe | sda_o);

	serial_control_target_bridge #(.STRAP_WAIT(STW)) i_dut (
		.clk, .rstn, .link_clk, .scl_i(scl), .scl_o, .scl_oe, .sda_i(sda), .sda_o, .sda_oe,
		.address_strap_pin(strap_v), .mode_strap_pin(mode_v), .rx_port_lock(lock), .gpio_pin(gp),
		.bc_tx_valid(bv), .bc_tx_word(bw), .bc_tx_ready(br), .bc_rx_valid(rv),
		.bc_rx_resp(rr), .proxy_valid(pv), .proxy_word(pw), .bc_rate_fast(rf)
	);
	bc_partner p (.link_clk, .rstn, .slow, .px, .v(bv), .w(bw), .rdy(br), .rv(rv), .r(rr));

	always #4 clk = ~clk;
	initial begin
		#1.3;
		forever #40 link_clk = ~link_clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 80000) begin
			n_errors++;
			final_report;
		end
	end

	function automatic logic [31:0] nx(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic int ix(input logic pt, input logic [7:0] o);
		return (o == 8'h58 || o == 8'h5d) ? int'({pt, o}) : int'(o);
	endfunction
	task automatic w(input int n);
		repeat (n) @(posedge clk);
	endtask
	// One bit; a held clock line is waited out and counted as stretch.
	task automatic bt(input logic b, output logic r);
		md <= b;
		w(Q);
		ms <= 1'b1;
		w(1);
		for (int k = 0; k < 20000 && !scl; k++) begin
			st++;
			w(1);
		end
		w(Q);
		r = sda;
		w(Q);
		ms <= 1'b0;
		w(Q);
	endtask
	task automatic tx(input logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) bt(b[i], r);
		bt(1'b1, r);
		`CHK(!r, ea)
	endtask
	task automatic rx(output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bt(1'b1, d[i]);
		bt(1'b1, r);
	endtask
	task automatic sta;
		st = 0;
		md <= 1'b1;
		w(Q);
		ms <= 1'b1;
		w(Q);
		md <= 1'b0;
		w(Q);
		ms <= 1'b0;
		w(Q);
	endtask
	task automatic sp;
		md <= 1'b0;
		w(Q);
		ms <= 1'b1;
		w(Q);
		md <= 1'b1;
		w(2 * Q);
	endtask
	task automatic wr(input logic [6:0] a, input logic pt, input logic [7:0] o, d);
		sta;
		tx({a, 1'b0});
		tx(o);
		tx(d);
		sp;
		mdl[ix(pt, o)] = d;
	endtask
	task automatic rd(input logic [6:0] a, input logic pt, input logic [7:0] o);
		sta;
		tx({a, 1'b0});
		tx(o);
		sta;
		tx({a, 1'b1});
		rx(rb);
		sp;
		`CHK(rb, mdl[ix(pt, o)])
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		for (int i = 0; i < 512; i++) mdl[i] = 8'h00;
		w(5);
		repeat (2) @(posedge link_clk);
		w(1);
		rstn <= 1'b1;
		w(STW + 60);
		`CHK(rf, 2'h3)
		mdl[0] = {7'h36, 1'b0};
		rd(7'h36, 1'b0, 8'h00);
		wr(7'h36, 1'b0, 8'h02, 8'h20);
		`CHK(st, 0)
		wr(7'h36, 1'b0, 8'hf8, 8'h88);
		wr(7'h36, 1'b0, 8'hf9, 8'h8a);
		rd(7'h44, 1'b0, 8'h02);
		wr(7'h45, 1'b1, 8'h58, 8'h09);
		wr(7'h36, 1'b0, 8'h58, 8'h08);
		rd(7'h44, 1'b0, 8'h58);
		rd(7'h45, 1'b1, 8'h58);
		`CHK(rf, 2'h2)
		$display("local tests done");
		wr(7'h36, 1'b0, 8'h5d, 8'ha0);
		lf = nx(lf);
		gp <= lf[11:8];
		slow <= 1'b1;
		sta;
		tx(8'ha0);
		tx(lf[7:0]);
		sp;
		`CHK(p.la, 8'ha0)
		`CHK(p.lw, lf[7:0])
		`CHK(st > 0, 1'b1)
		slow <= 1'b0;
		sta;
		tx(8'ha1);
		rx(rb);
		sp;
		`CHK(rb, 8'ha5)
		lock <= 2'h2;
		ea = 1'b0;
		sta;
		tx(8'ha0);
		sp;
		ea = 1'b1;
		$display("remote tests done");
		px <= 1'b1;
		for (int i = 0; i < 400 && pv !== 1'b1; i++) @(negedge clk);
		`CHK(pw, 11'h55a)
		`CHK(p.caps, 8'h01)
		$display("proxy tests done");
		strap_v <= 3'h7;
		mode_v <= 1'b0;
		rstn <= 1'b0;
		w(5);
		repeat (2) @(posedge link_clk);
		w(1);
		rstn <= 1'b1;
		w(STW + 60);
		`CHK(rf, 2'h0)
		mdl[0] = {7'h3d, 1'b0};
		rd(7'h3d, 1'b0, 8'h00);
		$display("strap tests done");
		final_report;
	end
endmodule
